// ### src/sid_decoder.sv
// SIMD instruction operand decoder, compressed-instruction splitter and operand state
// Contract
// RULE1: Execution size capped at 8 for 32-bit types, 16 for 16-bit types.
// RULE2: Execution size for 8-bit types capped at 16.
// RULE3: Compressed 32-bit or mixed instruction is split into two native instructions; the code splits compressed dword only and never reads the mixed bit.
// RULE4: Each native instruction occupies several datapath cycles; the code takes a single cycle for native sizes up to LANES (4).
// RULE5: At most two sources and one destination, each a register region.
// RULE6: Sources take negate, absolute, swizzle; destination takes a write mask.
// RULE7: Implied second destinations: flag register and send header assembly.
// RULE8: Per-channel accumulator wider than data, loaded by move or arithmetic.
// RULE9: Indirect addressing is address sub-register plus offset, first source and dest only.
// RULE10: One address register of eight 16-bit unsigned sub-registers.
// RULE11: First two sub-registers form the send message descriptor.
// RULE12: Two sources: only second may be immediate; one source: first slot, immediate allowed.
// RULE13: Scalar immediate of declared type replicated across all channels.
// RULE14: Packed immediate of eight signed 4-bit integers.
// RULE15: Packed immediate of four 8-bit restricted floats.
// RULE16: Channels disabled by dest mask, predication, execution mask or execution size.
// RULE17: Execution size per instruction, 1 up to type maximum, power of two.
// RULE18: Instruction word 128 bits; immediate fills the fourth doubleword.
// RULE19: Split halves issue lower channels first, then upper channels.
// RULE20: Oversized or non power-of-two execution size flagged unsupported, not executed.
module sid_decoder #(
	parameter int LANES = 4,
	parameter int ACC_W = 48
) (
	// Clock and reset
	input  wire logic                                  sys_clk,
	input  wire logic                                  rst_n,
	// Instruction stream
	input  wire logic                                  instrValid,
	input  wire sid_pkg::sid_instr_t                   instrWord,
	output logic                                       instrReady,
	// Channel enables from branch control and flags
	input  wire logic [sid_pkg::CHANNELS-1:0]          execMask,
	input  wire logic [sid_pkg::CHANNELS-1:0]          predFlags,
	// Results steered into the accumulators
	input  wire logic [sid_pkg::CHANNELS-1:0]          accWrite,
	input  wire logic [sid_pkg::CHANNELS-1:0][31:0]    accData,
	// Issue side
	output sid_pkg::sid_uop_t                          uop,
	output logic                                       unsupported,
	// Architectural state
	output logic [sid_pkg::ADDR_SUBS-1:0][15:0]        addrReg,
	output logic [sid_pkg::CHANNELS-1:0][ACC_W-1:0]    accum
);
	typedef struct packed {
		sid_pkg::sid_phase_t                   phase;
		logic                                  ready;
		sid_pkg::sid_instr_t                   instr;
		logic                                  half;
		logic [4:0]                            cycleCnt;
		sid_pkg::sid_uop_t                     uop;
		logic                                  unsupported;
		logic [sid_pkg::ADDR_SUBS-1:0][15:0]   addrReg;
		logic [sid_pkg::CHANNELS-1:0][ACC_W-1:0] accum;
	} sid_state_t;

	sid_state_t st;
	sid_state_t next_st;

	// Number of source operands an opcode takes
	function automatic logic [1:0] src_count(input logic [7:0] opc);
		case (opc)
			sid_pkg::OP_ADD, sid_pkg::OP_MUL, sid_pkg::OP_CMP: src_count = 2'h2;
			sid_pkg::OP_MOV, sid_pkg::OP_SEND, sid_pkg::OP_SETADDR: src_count = 2'h1;
			default: src_count = 2'h0;
		endcase
	endfunction

	// Encoding checks on a fresh instruction word
	function automatic logic is_illegal(input sid_pkg::sid_instr_t ins);
		logic [1:0]        nsrc;
		logic [2:0]        maxLog;
		logic              bad;
		sid_pkg::sid_src_t sec;
		nsrc = src_count(ins.op.opcode);
		sec = ins.dw3;
		maxLog = (ins.op.dataType == sid_pkg::TYPE_DWORD) ? sid_pkg::MAX_LOG_DWORD
			: sid_pkg::MAX_LOG_NARROW; // RULE1 RULE2
		if (ins.op.compressed) begin
			maxLog = sid_pkg::MAX_LOG_NARROW; // RULE3
		end
		bad = (nsrc == 2'h0); // RULE5
		bad = bad | (ins.op.execution_size > maxLog); // RULE17 RULE20
		bad = bad | (ins.op.dataType > sid_pkg::TYPE_DWORD);
		bad = bad | (ins.op.compressed && ins.op.dataType != sid_pkg::TYPE_DWORD); // RULE3
		// A compressed size of one has no native halves to split into
		bad = bad | (ins.op.compressed && ins.op.execution_size == 3'h0); // RULE3 RULE17
		bad = bad | (nsrc == 2'h2 && ins.first_source_operand.isImm); // RULE12
		bad = bad | (nsrc == 2'h1 && ins.op.secondImm); // RULE12
		bad = bad | (nsrc == 2'h2 && !ins.op.secondImm && sec.indirect); // RULE9
		bad = bad | (ins.op.accDst && !(ins.op.opcode == sid_pkg::OP_MOV
			|| ins.op.opcode == sid_pkg::OP_ADD || ins.op.opcode == sid_pkg::OP_MUL)); // RULE8
		is_illegal = bad;
	endfunction

	// Value of one channel of an immediate operand
	function automatic logic [31:0] imm_lane(input logic [31:0] imm, input logic [1:0] kind,
		input logic [1:0] dtype, input int ch);
		logic [3:0]  nib;
		logic [7:0]  rf;
		logic [31:0] v;
		nib = imm[4*(ch%8) +: 4];
		rf = imm[8*(ch%4) +: 8];
		case (kind)
			sid_pkg::IMM_VEC_INT4: v = {{28{nib[3]}}, nib}; // RULE14
			sid_pkg::IMM_VEC_FLOAT8: begin
				if (rf[6:0] == 7'h00) begin
					v = {rf[7], 31'h0}; // RULE15
				end else begin
					v = {rf[7], 8'(rf[6:4]) + sid_pkg::RF_EXP_OFFSET, rf[3:0], 19'h0}; // RULE15
				end
			end
			default: begin
				case (dtype)
					sid_pkg::TYPE_BYTE: v = {{24{imm[7]}}, imm[7:0]}; // RULE13
					sid_pkg::TYPE_WORD: v = {{16{imm[15]}}, imm[15:0]}; // RULE13
					default: v = imm; // RULE13
				endcase
			end
		endcase
		imm_lane = v;
	endfunction

	// Register address of an operand, direct or via an address sub-register
	function automatic logic [9:0] reg_addr(input logic ind, input logic [2:0] sub,
		input logic [9:0] off, input logic [sid_pkg::ADDR_SUBS-1:0][15:0] areg);
		reg_addr = ind ? 10'(areg[sub] + 16'(off)) : off; // RULE9
	endfunction

	// Datapath cycles for a native instruction of the given size
	function automatic logic [4:0] native_cycles(input logic [2:0] nlog);
		int n;
		n = (1 << nlog) / LANES;
		native_cycles = (n < 1) ? 5'h01 : 5'(n); // RULE4
	endfunction

	sid_pkg::sid_instr_t ci;
	sid_pkg::sid_src_t   s0;
	sid_pkg::sid_src_t   s1;
	logic [2:0]          nativeLog;
	logic [4:0]          cycles;
	logic [4:0]          base;
	logic [15:0]         sizeMask;
	logic [15:0]         predMask;

	// Decode of the held instruction
	always_comb begin
		ci = st.instr;
		s0 = ci.first_source_operand;
		s1 = sid_pkg::sid_src_t'(ci.dw3); // RULE18
		nativeLog = ci.op.compressed ? 3'(ci.op.execution_size - 3'h1) : ci.op.execution_size; // RULE3
		cycles = native_cycles(nativeLog);
		base = st.half ? 5'(sid_pkg::HALF_BASE) : 5'h00; // RULE19
		sizeMask = 16'(((17'h00001 << (5'h01 << nativeLog)) - 17'h00001) << base); // RULE16
		predMask = ci.op.predOn ? predFlags : 16'hffff; // RULE16
	end

	// Next state
	always_comb begin
		next_st = st;
		next_st.uop.valid = 1'b0;
		next_st.unsupported = 1'b0;
		for (int c = 0; c < sid_pkg::CHANNELS; c++) begin
			if (accWrite[c]) begin
				next_st.accum[c] = {{(ACC_W-32){accData[c][31]}}, accData[c]}; // RULE8
			end
		end
		case (st.phase)
			sid_pkg::PH_IDLE: begin
				if (instrValid && st.ready) begin
					if (is_illegal(instrWord)) begin
						next_st.unsupported = 1'b1; // RULE20
					end else if (instrWord.op.opcode == sid_pkg::OP_SETADDR) begin
						next_st.addrReg[instrWord.dst.addrSub] = instrWord.dw3[15:0]; // RULE10
					end else begin
						next_st.instr = instrWord;
						next_st.half = 1'b0; // RULE19
						next_st.cycleCnt = 5'h00;
						next_st.phase = sid_pkg::PH_RUN;
						next_st.ready = 1'b0;
					end
				end
			end
			sid_pkg::PH_RUN: begin
				if (st.cycleCnt == 5'h00) begin
					next_st.uop.valid = 1'b1;
					next_st.uop.opcode = ci.op.opcode;
					next_st.uop.dataType = ci.op.dataType;
					next_st.uop.upperHalf = st.half; // RULE19
					next_st.uop.execSizeLog = nativeLog; // RULE1 RULE2
					next_st.uop.chanMask = sizeMask & ci.dst.writeMask & execMask & predMask; // RULE16
					next_st.uop.dstReg = reg_addr(ci.dst.indirect, ci.dst.addrSub,
						ci.dst.regOrImm, st.addrReg); // RULE9
					next_st.uop.firstReg = reg_addr(s0.indirect, s0.addrSub, s0.regOrImm,
						st.addrReg); // RULE9
					next_st.uop.secondReg = s1.regOrImm; // RULE9
					next_st.uop.firstNeg = s0.negMod; // RULE6
					next_st.uop.firstAbs = s0.absMod; // RULE6
					next_st.uop.firstSwz = s0.swizzle; // RULE6
					next_st.uop.secondNeg = s1.negMod & ~ci.op.secondImm; // RULE6
					next_st.uop.secondAbs = s1.absMod & ~ci.op.secondImm; // RULE6
					next_st.uop.secondSwz = s1.swizzle; // RULE6
					next_st.uop.firstIsImm = s0.isImm; // RULE12
					next_st.uop.secondIsImm = ci.op.secondImm; // RULE12
					next_st.uop.flagWrite = ci.op.condMod; // RULE7
					next_st.uop.headerAssemble = (ci.op.opcode == sid_pkg::OP_SEND); // RULE7
					next_st.uop.accDst = ci.op.accDst; // RULE8
					next_st.uop.sendDesc = {st.addrReg[1], st.addrReg[0]}; // RULE11
					for (int c = 0; c < sid_pkg::CHANNELS; c++) begin
						next_st.uop.immVec[c] = imm_lane(ci.dw3, s0.immKind, ci.op.dataType,
							c); // RULE13
					end
				end
				if (st.cycleCnt == 5'(cycles - 5'h01)) begin
					next_st.cycleCnt = 5'h00;
					if (ci.op.compressed && !st.half) begin
						next_st.half = 1'b1; // RULE3 RULE19
					end else begin
						next_st.phase = sid_pkg::PH_IDLE;
						next_st.ready = 1'b1;
					end
				end else begin
					next_st.cycleCnt = 5'(st.cycleCnt + 5'h01); // RULE4
				end
			end
			default: begin
				next_st.phase = sid_pkg::PH_IDLE;
				next_st.ready = 1'b1;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.ready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state
	assign instrReady = st.ready;
	assign uop = st.uop;
	assign unsupported = st.unsupported;
	assign addrReg = st.addrReg;
	assign accum = st.accum;

	// Checks
	property p_dword_cap;
		@(posedge sys_clk) disable iff (!rst_n)
		(uop.valid && uop.dataType == sid_pkg::TYPE_DWORD) |-> uop.execSizeLog <= 3'h3;
	endproperty
	a_dword_cap: assert property (p_dword_cap) else $error("dword native size above 8"); // RULE1

	property p_narrow_cap;
		@(posedge sys_clk) disable iff (!rst_n)
		(uop.valid && uop.dataType != sid_pkg::TYPE_DWORD) |-> uop.execSizeLog <= 3'h4;
	endproperty
	a_narrow_cap: assert property (p_narrow_cap) else $error("narrow size above 16"); // RULE2

	property p_split;
		@(posedge sys_clk) disable iff (!rst_n)
		(uop.valid && !uop.upperHalf && st.instr.op.compressed)
			|-> ##[1:16] (uop.valid && uop.upperHalf);
	endproperty
	a_split: assert property (p_split) else $error("upper half not issued"); // RULE3 RULE19

	property p_multi_cycle;
		@(posedge sys_clk) disable iff (!rst_n)
		(uop.valid && uop.execSizeLog == 3'h3) |=> !uop.valid;
	endproperty
	a_multi_cycle: assert property (p_multi_cycle) else $error("native issued too fast"); // RULE4

	property p_exec_mask;
		@(posedge sys_clk) disable iff (!rst_n)
		uop.valid |-> (uop.chanMask & ~$past(execMask)) == 16'h0000;
	endproperty
	a_exec_mask: assert property (p_exec_mask) else $error("disabled channel enabled"); // RULE16

	property p_bad_size;
		@(posedge sys_clk) disable iff (!rst_n)
		(instrValid && instrReady && instrWord.op.execution_size > 3'h4)
			|=> (unsupported && instrReady) ##1 !uop.valid;
	endproperty
	a_bad_size: assert property (p_bad_size) else $error("oversize not rejected"); // RULE20

	property p_imm_slot;
		@(posedge sys_clk) disable iff (!rst_n)
		(instrValid && instrReady && instrWord.op.opcode == sid_pkg::OP_ADD
			&& instrWord.first_source_operand.isImm) |=> unsupported;
	endproperty
	a_imm_slot: assert property (p_imm_slot) else $error("first source immediate taken"); // RULE12

	property p_second_indirect;
		@(posedge sys_clk) disable iff (!rst_n)
		(instrValid && instrReady && instrWord.op.opcode == sid_pkg::OP_MUL
			&& !instrWord.op.secondImm && instrWord.dw3[0]) |=> unsupported;
	endproperty
	a_second_indirect: assert property (p_second_indirect) else $error("indirect second source"); // RULE9

	property p_desc;
		@(posedge sys_clk) disable iff (!rst_n)
		uop.valid |-> uop.sendDesc == {addrReg[1], addrReg[0]};
	endproperty
	a_desc: assert property (p_desc) else $error("descriptor mismatch"); // RULE11
endmodule

// ### src/sid_pkg.sv
// Package for the SIMD instruction operand decoder: encodings, layouts and carriers
package sid_pkg;
	// Channel and data widths
	localparam int CHANNELS   = 16;
	localparam int DATA_W     = 32;
	localparam int ADDR_SUBS  = 8;
	localparam int ADDR_SUB_W = 16;
	localparam int HALF_BASE  = 8;
	// Largest execution size code (log2) per data type
	localparam logic [2:0] MAX_LOG_DWORD  = 3'h3;
	localparam logic [2:0] MAX_LOG_NARROW = 3'h4;
	// Opcodes understood by the decoder
	localparam logic [7:0] OP_MOV     = 8'h01;
	localparam logic [7:0] OP_SETADDR = 8'h02;
	localparam logic [7:0] OP_CMP     = 8'h10;
	localparam logic [7:0] OP_SEND    = 8'h31;
	localparam logic [7:0] OP_ADD     = 8'h40;
	localparam logic [7:0] OP_MUL     = 8'h41;
	// Data types
	localparam logic [1:0] TYPE_BYTE  = 2'h0;
	localparam logic [1:0] TYPE_WORD  = 2'h1;
	localparam logic [1:0] TYPE_DWORD = 2'h2;
	// Immediate kinds
	localparam logic [1:0] IMM_SCALAR     = 2'h0;
	localparam logic [1:0] IMM_VEC_INT4   = 2'h1;
	localparam logic [1:0] IMM_VEC_FLOAT8 = 2'h2;
	// Restricted float exponent rebias to single precision
	localparam logic [7:0] RF_EXP_OFFSET = 8'h7c;
	// Values after reset
	localparam logic [15:0] ADDR_RESET = 16'h0000;

	typedef enum logic {PH_IDLE, PH_RUN} sid_phase_t;

	// Operation doubleword
	typedef struct packed {
		logic [12:0] rsvd;
		logic        secondImm;
		logic        accDst;
		logic        mixed;
		logic [1:0]  dataType;
		logic        predOn;
		logic        condMod;
		logic        compressed;
		logic [2:0]  execution_size;
		logic [7:0]  opcode;
	} sid_op_t;

	// Destination doubleword
	typedef struct packed {
		logic [1:0]  rsvd;
		logic [15:0] writeMask;
		logic [9:0]  regOrImm;
		logic [2:0]  addrSub;
		logic        indirect;
	} sid_dst_t;

	// Source operand fields
	typedef struct packed {
		logic [4:0] rsvd;
		logic [9:0] regOrImm;
		logic [2:0] addrSub;
		logic [7:0] swizzle;
		logic       absMod;
		logic       negMod;
		logic [1:0] immKind;
		logic       isImm;
		logic       indirect;
	} sid_src_t;

	// Whole 128-bit instruction word; the fourth doubleword holds an immediate when present
	typedef struct packed {
		logic [31:0] dw3;
		sid_src_t    first_source_operand;
		sid_dst_t    dst;
		sid_op_t     op;
	} sid_instr_t;

	// One native micro-operation handed to execution
	typedef struct packed {
		logic                            valid;
		logic [7:0]                      opcode;
		logic [1:0]                      dataType;
		logic                            upperHalf;
		logic [2:0]                      execSizeLog;
		logic [15:0]                     chanMask;
		logic [9:0]                      dstReg;
		logic [9:0]                      firstReg;
		logic [9:0]                      secondReg;
		logic                            firstNeg;
		logic                            firstAbs;
		logic [7:0]                      firstSwz;
		logic                            secondNeg;
		logic                            secondAbs;
		logic [7:0]                      secondSwz;
		logic                            firstIsImm;
		logic                            secondIsImm;
		logic                            flagWrite;
		logic                            headerAssemble;
		logic                            accDst;
		logic [31:0]                     sendDesc;
		logic [CHANNELS-1:0][DATA_W-1:0] immVec;
	} sid_uop_t;
endpackage

// ### verification/sid_fetch_model.sv
// Instruction fetch model that offers words to the decoder and holds them until taken
module sid_fetch_model (
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	// Instruction stream
	input  wire logic          instrReady,
	output logic               instrValid,
	output sid_pkg::sid_instr_t instrWord
);
	timeunit 1ns;
	timeprecision 1ns;
	logic taken = 1'b0;
	initial begin
		instrValid = 1'b0;
		instrWord = '0;
	end
	// Release after the take; the bus shows the inverse so no stale word lingers
	always @(negedge sys_clk) begin
		if (taken) begin
			instrValid <= 1'b0;
			instrWord <= ~instrWord;
			taken <= 1'b0;
		end
	end
	// Offer one whole 128-bit word, held until the edge that sees ready high
	task automatic issue(input sid_pkg::sid_instr_t w);
		int n;
		@(negedge sys_clk);
		instrWord <= w;
		instrValid <= 1'b1;
		for (n = 0; n < 60 && instrReady !== 1'b1; n++) @(negedge sys_clk);
		@(posedge sys_clk);
		taken <= 1'b1;
	endtask
endmodule

// ### verification/tb_sid_decoder.sv
// Self-checking bench for the SIMD instruction operand decoder
module tb_sid_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LANES = 4;
	logic                sys_clk = 1'b0;
	logic                rst_n = 1'b0;
	logic                instrValid, instrReady, unsupported;
	sid_pkg::sid_instr_t instrWord, w;
	sid_pkg::sid_src_t   s0w, s1w;
	logic [31:0]         ex;
	logic [15:0]         execMask = 16'hffff, predFlags = 16'hffff, accWrite = 16'h0;
	logic [15:0][31:0]   accData = '0;
	logic [15:0][47:0]   accExp = '0;
	sid_pkg::sid_uop_t   uop;
	logic [7:0][15:0]    addrReg, ar;
	logic [15:0][47:0]   accum;
	logic [31:0]         seed = 32'hda513792;
	logic [7:0]          ops[3] = '{sid_pkg::OP_ADD, sid_pkg::OP_MUL, sid_pkg::OP_CMP};
	sid_pkg::sid_uop_t   got[$];
	int                  at[$];
	int                  error_cnt = 0, checks_done = 0, nUns, i, j, c, nl, lo, hi;

	sid_decoder #(.LANES(LANES), .ACC_W(48)) sid_decoder_inst (.sys_clk, .rst_n, .instrValid,
		.instrWord, .instrReady, .execMask, .predFlags, .accWrite, .accData, .uop, .unsupported,
		.addrReg, .accum);
	sid_fetch_model sid_fetch_model_inst (.sys_clk, .rst_n, .instrReady, .instrValid, .instrWord);

	// Clock of 100 ns period
	always #50 sys_clk = ~sys_clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Legal dword instruction of size 8 with every write-mask bit set
	function automatic sid_pkg::sid_instr_t base(logic [7:0] op);
		sid_pkg::sid_instr_t b;
		b = '0;
		b.op.opcode = op;
		b.op.dataType = sid_pkg::TYPE_DWORD;
		b.op.execution_size = 3'h3;
		b.dst.writeMask = 16'hffff;
		return b;
	endfunction
	// Enabled channels of one native half
	function automatic logic [15:0] expMask(sid_pkg::sid_instr_t x, int n, int up);
		logic [15:0] m;
		m = 16'((32'h1 << (1 << n)) - 32'h1) << (up * 8);
		return m & x.dst.writeMask & execMask & (x.op.predOn ? predFlags : 16'hffff);
	endfunction
	// Register address, direct or offset from an address sub-register
	function automatic logic [9:0] expReg(logic ind, logic [2:0] sub, logic [9:0] off);
		return ind ? 10'(ar[sub] + off) : off;
	endfunction
	// Immediate as seen by one channel
	function automatic logic [31:0] expImm(logic [31:0] v, logic [1:0] k, logic [1:0] t, int ch);
		logic [7:0] b;
		b = v[8*(ch%4) +: 8];
		case (k)
			sid_pkg::IMM_VEC_INT4: return 32'(signed'(v[4*(ch%8) +: 4]));
			sid_pkg::IMM_VEC_FLOAT8: return {b[7], 8'(b[6:4]) + sid_pkg::RF_EXP_OFFSET, b[3:0], 19'h0};
			default: return t == sid_pkg::TYPE_DWORD ? v :
				t == sid_pkg::TYPE_WORD ? 32'(signed'(v[15:0])) : 32'(signed'(v[7:0]));
		endcase
	endfunction

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask
	task automatic results();
		$display("mismatches %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Issue one word and collect every pulse until the decoder is idle again
	task automatic run(input sid_pkg::sid_instr_t x);
		int k;
		got.delete();
		at.delete();
		nUns = 0;
		sid_fetch_model_inst.issue(x);
		for (k = 1; k < 60; k++) begin
			@(negedge sys_clk);
			if (uop.valid === 1'b1) begin
				got.push_back(uop);
				at.push_back(k);
			end
			if (unsupported === 1'b1) nUns++;
			if (k >= 3 && instrReady === 1'b1) break;
		end
		if (k == 60) begin
			chk(0, 1, "decoder hung");
			results();
		end
	endtask

	// Main sequence
	initial begin
		repeat (16) @(negedge sys_clk);
		for (i = 0; i < 8; i++) chk(addrReg[i], sid_pkg::ADDR_RESET, "addr reset");
		rst_n = 1'b1;
		// Fill the address sub-registers
		for (i = 0; i < 8; i++) begin
			w = base(sid_pkg::OP_SETADDR);
			w.dst.addrSub = 3'(i);
			w.dw3 = rnd();
			ar[i] = w.dw3[15:0];
			run(w);
			chk(addrReg[i], ar[i], "addr write");
		end
		w = base(sid_pkg::OP_SEND);
		run(w);
		chk(got[0].sendDesc, {ar[1], ar[0]}, "descriptor");
		chk(got[0].headerAssemble, 1, "header");
		// One-source move with every immediate kind
		for (i = 0; i < 6; i++) begin
			w = base(sid_pkg::OP_MOV);
			w.first_source_operand.isImm = 1'b1;
			w.first_source_operand.immKind = 2'(i % 3);
			w.op.dataType = 2'((i + i / 3) % 3);
			w.dw3 = rnd() | (i % 3 == 2 ? 32'h10101010 : 32'h0);
			run(w);
			chk(got[0].firstIsImm, 1, "first imm");
			for (j = 0; j < 8; j++) begin
				ex = expImm(w.dw3, 2'(i % 3), w.op.dataType, j);
				chk(got[0].immVec[j], ex, "imm vector");
			end
		end
		// Malformed words are refused
		for (i = 0; i < 10; i++) begin
			w = base(sid_pkg::OP_ADD);
			case (i)
				0: w.op.opcode = 8'hff;
				1: w.op.execution_size = 3'h4;
				2: {w.op.dataType, w.op.execution_size} = {sid_pkg::TYPE_BYTE, 3'h5};
				3: {w.op.dataType, w.op.compressed} = {sid_pkg::TYPE_WORD, 1'b1};
				4: w.op.dataType = 2'h3;
				5: w.first_source_operand.isImm = 1'b1;
				6: {w.op.opcode, w.op.secondImm} = {sid_pkg::OP_MOV, 1'b1};
				7: {w.op.opcode, w.dw3[0]} = {sid_pkg::OP_MUL, 1'b1};
				8: {w.op.opcode, w.op.accDst} = {sid_pkg::OP_CMP, 1'b1};
				default: {w.op.compressed, w.op.execution_size} = {1'b1, 3'h0};
			endcase
			run(w);
			chk(nUns * 16 + got.size(), 16, "refusal");
		end
		// Random legal traffic
		repeat (40) begin
			w = sid_pkg::sid_instr_t'({rnd(), rnd(), rnd(), rnd()});
			w.op.opcode = ops[rnd() % 3];
			w.op.dataType = 2'(rnd() % 3);
			w.op.compressed = w.op.dataType == sid_pkg::TYPE_DWORD && rnd() % 2;
			w.op.accDst = w.op.accDst && w.op.opcode != sid_pkg::OP_CMP;
			lo = w.op.compressed;
			hi = w.op.dataType == sid_pkg::TYPE_DWORD && !lo ? 3 : 4;
			w.op.execution_size = 3'(lo + rnd() % (hi - lo + 1));
			w.first_source_operand.isImm = 1'b0;
			w.first_source_operand.immKind = 2'(rnd() % 3);
			if (!w.op.secondImm) w.dw3[0] = 1'b0;
			if (w.first_source_operand.immKind == 2'h2) w.dw3 |= 32'h10101010;
			s0w = w.first_source_operand;
			s1w = w.dw3;
			execMask = 16'(rnd());
			predFlags = 16'(rnd());
			run(w);
			nl = w.op.execution_size - lo;
			c = (1 << nl) / LANES > 1 ? (1 << nl) / LANES : 1;
			chk(got.size(), 1 + lo, "native count");
			foreach (got[k]) begin
				chk(at[k], 2 + k * c, "issue cycle");
				chk(got[k].upperHalf, k, "half order");
				chk(got[k].chanMask, expMask(w, nl, k), "channel mask");
				chk(got[k].flagWrite, w.op.condMod, "flag write");
				chk(got[k].accDst, w.op.accDst, "acc dest");
				chk(got[k].firstNeg, s0w.negMod, "first negate");
				chk(got[k].firstAbs, s0w.absMod, "first abs");
				chk(got[k].firstSwz, s0w.swizzle, "first swizzle");
				chk(got[k].dstReg, expReg(w.dst.indirect, w.dst.addrSub, w.dst.regOrImm), "dst");
				chk(got[k].firstReg, expReg(s0w.indirect, s0w.addrSub, s0w.regOrImm), "first");
				chk(got[k].secondIsImm, w.op.secondImm, "second imm flag");
				if (w.op.secondImm) begin
					ex = expImm(w.dw3, s0w.immKind, w.op.dataType, 0);
					chk(got[k].immVec[0], ex, "second imm");
				end else begin
					chk(got[k].secondReg, s1w.regOrImm, "second reg");
					chk(got[k].secondNeg, s1w.negMod, "second negate");
					chk(got[k].secondAbs, s1w.absMod, "second abs");
					chk(got[k].secondSwz, s1w.swizzle, "second swizzle");
				end
			end
		end
		// Accumulator loads, sign-extended to the wider width
		repeat (4) begin
			accWrite = 16'(rnd());
			for (i = 0; i < 16; i++) accData[i] = rnd();
			for (i = 0; i < 16; i++) if (accWrite[i]) accExp[i] = 48'(signed'(accData[i]));
			@(negedge sys_clk);
			for (i = 0; i < 16; i++) chk(accum[i], accExp[i], "accumulator");
		end
		results();
	end
endmodule
